// ### testbench/bcu_branch_unit_tb.sv
// Self-checking bench for the branch control unit.
// Assumes a 20 MHz clock and the program memory model beside the unit.
`timescale 1ns/1ns
`default_nettype none
module bcu_branch_unit_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic send = 1'b0;
	logic [15:0] word = 16'h0000;
	logic [31:0] acc = 32'h00000000;
	logic ld = 1'b0;
	logic [15:0] ld_val = 16'h0000;
	logic valid;
	logic [15:0] pword;
	logic [11:0] ip;
	logic [15:0] idx;
	logic busy;
	logic taken;
	logic [11:0] exp_ip = 12'h000;
	int err_total = 0;
	int samples_checked = 0;
	always #25 clk = ~clk;
	bcu_prog_mem i_mem (.clk(clk), .send(send), .word_in(word),
		.word_valid(valid), .word_out(pword));
	bcu_branch_unit i_dut (.REF_CLK(clk), .RST_N(rst_n), .WORD_VALID(valid),
		.PROGRAM_WORD(pword), .ACCUMULATOR(acc), .INDEX_LOAD(ld),
		.INDEX_LOAD_VALUE(ld_val), .INSTRUCTION_POINTER(ip),
		.INDEX_COUNTER(idx), .BRANCH_BUSY(busy), .BRANCH_TAKEN(taken));
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic put(input logic [15:0] w);
		@(posedge clk);
		send <= 1'b1;
		word <= w;
	endtask : put
	task automatic load(input logic [15:0] v);
		@(posedge clk);
		ld <= 1'b1;
		ld_val <= v;
		@(posedge clk);
		ld <= 1'b0;
		@(negedge clk);
		chk(idx, v);
	endtask : load
	// A gap holds the word strobe low while the unit waits for the target.
	task automatic br(input logic [15:0] op, input logic [15:0] tgt,
			input logic tk, input int gap);
		put(op);
		repeat (gap) begin
			@(posedge clk);
			send <= 1'b0;
		end
		put(tgt);
		@(negedge clk);
		chk({15'h0000, busy}, 16'h0001);
		@(posedge clk);
		send <= 1'b0;
		exp_ip = tk ? tgt[11:0] : exp_ip + 12'h002;
		@(negedge clk);
		chk({4'h0, ip}, {4'h0, exp_ip});
		chk({15'h0000, taken}, {15'h0000, tk});
		chk({15'h0000, busy}, 16'h0000);
	endtask : br
	// ==========================================================
	// Scenarios
	task automatic t_step;
		put(16'h1234);
		put(16'h7000);
		@(posedge clk);
		send <= 1'b0;
		exp_ip = exp_ip + 12'h002;
		@(negedge clk);
		chk({4'h0, ip}, {4'h0, exp_ip});
	endtask : t_step
	task automatic t_jump;
		br(16'hF900, 16'hAFFF, 1'b1, 0);
		br(16'hF900, 16'h0000, 1'b1, 1);
	endtask : t_jump
	task automatic t_loop;
		load(16'h0001);
		br(16'hF400, 16'h0035, 1'b1, 0);
		chk(idx, 16'h0000);
		load(16'hFE00);
		br(16'hF400, 16'h0123, 1'b0, 2);
		chk(idx, 16'hFFFF);
	endtask : t_loop
	task automatic t_nonneg;
		@(posedge clk) acc <= 32'h00000000;
		br(16'hFD00, 16'h0217, 1'b1, 0);
		@(posedge clk) acc <= 32'h80000000;
		br(16'hFD00, 16'h0217, 1'b0, 0);
		@(posedge clk) acc <= 32'h7FFFFFFF;
		br(16'hFD00, 16'h0FFF, 1'b1, 0);
	endtask : t_nonneg
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_step();
		t_jump();
		t_loop();
		t_nonneg();
		conclude();
	end
	// The tests need under 100 cycles, so this span only ends a hang.
	initial begin
		#100000;
		err_total++;
		conclude();
	end
endmodule : bcu_branch_unit_tb
`default_nettype wire

// ### testbench/bcu_prog_mem.sv
// Program memory model that hands fetched words to the branch unit.
// Assumes the bench asks for at most one word per clock edge.
`timescale 1ns/1ns
`default_nettype none
module bcu_prog_mem (
	input wire logic clk,
	input wire logic send,
	input wire logic [15:0] word_in,
	output logic word_valid,
	output logic [15:0] word_out
);
	logic [15:0] last_reg = 16'h0000;
	always_ff @(posedge clk) begin
		if (send) begin
			last_reg <= word_in;
		end
	end
	// An idle bus shows the inverse of the last word, so stale data is seen.
	assign word_valid = send;
	assign word_out = send ? word_in : ~last_reg;
endmodule : bcu_prog_mem
`default_nettype wire

// ### verilog/bcu_branch_unit.sv
// Branch control unit: executes three two-word branch instructions.
// Assumes the fetch path presents one word per cycle with WORD_VALID.
// How it works
// - The unconditional jump always loads the pointer with the target word.
// - The loop jump loads the target when the low nine index bits are nonzero.
// - The loop jump advances the pointer by two when those bits are zero.
// - The loop jump decrements the index register every time it runs.
// - The zero test uses the index value from before the decrement.
// - The index register counts modulo 512 in its low nine bits.
// - The nonnegative jump loads the target when the accumulator is >= 0.
`timescale 1ns/1ns
`default_nettype none
module bcu_branch_unit #(
	parameter int IP_W = bcu_pkg::IP_WIDTH,
	parameter int ACC_W = bcu_pkg::ACC_WIDTH
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic WORD_VALID,
	input wire logic [15:0] PROGRAM_WORD,
	input wire logic [ACC_W-1:0] ACCUMULATOR,
	input wire logic INDEX_LOAD,
	input wire logic [15:0] INDEX_LOAD_VALUE,
	output logic [IP_W-1:0] INSTRUCTION_POINTER,
	output logic [15:0] INDEX_COUNTER,
	output logic BRANCH_BUSY,
	output logic BRANCH_TAKEN
);
	// ==========================================================
	// Parameter checks
	if (IP_W != bcu_pkg::IP_WIDTH) begin : g_bad_ip_width
		$error("Pointer width must be 12.");
	end
	if (ACC_W < 2) begin : g_bad_acc_width
		$error("Accumulator too narrow.");
	end
	// ==========================================================
	// State
	bcu_pkg::bcu_state_e state_reg;
	bcu_pkg::bcu_state_e state_next;
	logic [IP_W-1:0] instruction_pointer_reg;
	logic [15:0] index_counter_reg;
	logic [15:0] index_dec;
	logic index_nonzero;
	logic taken_reg;
	logic take;

	bcu_index_dec #(.WIDTH(16)) u_dec (
		.VALUE_IN(index_counter_reg),
		.VALUE_OUT(index_dec),
		.NONZERO(index_nonzero)
	);

	// ==========================================================
	// Decode
	// opcode recognition
	always_comb begin
		state_next = bcu_pkg::BCU_IDLE;
		if (state_reg == bcu_pkg::BCU_IDLE && WORD_VALID) begin
			case (PROGRAM_WORD)
				bcu_pkg::OP_JUMP: state_next = bcu_pkg::BCU_JUMP;
				bcu_pkg::OP_LOOP_JUMP_NONZERO: state_next = bcu_pkg::BCU_LOOP;
				bcu_pkg::OP_JUMP_IF_NONNEGATIVE: state_next = bcu_pkg::BCU_NONNEG;
				default: state_next = bcu_pkg::BCU_IDLE;
			endcase
		end else if (state_reg != bcu_pkg::BCU_IDLE && !WORD_VALID) begin
			// The second word has not arrived yet, so hold.
			state_next = state_reg;
		end
	end

	always_comb begin
		case (state_reg)
			bcu_pkg::BCU_JUMP: take = 1'b1;
			bcu_pkg::BCU_LOOP: take = index_nonzero;
			bcu_pkg::BCU_NONNEG: take = ~ACCUMULATOR[ACC_W-1];
			default: take = 1'b0;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			state_reg <= bcu_pkg::BCU_IDLE;
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// Instruction pointer
	// The pointer does not move on the opcode word; it moves once per branch.
	// Both advances wrap at the top of program space.
	function automatic logic [IP_W-1:0] ip_advance(
		input logic [IP_W-1:0] base,
		input logic [IP_W-1:0] step
	);
		return base + step;
	endfunction : ip_advance

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			instruction_pointer_reg <= bcu_pkg::IP_RESET;
			taken_reg <= 1'b0;
		end else if (state_reg == bcu_pkg::BCU_IDLE) begin
			taken_reg <= 1'b0;
			if (WORD_VALID && state_next == bcu_pkg::BCU_IDLE)
				instruction_pointer_reg <= ip_advance(instruction_pointer_reg,
					bcu_pkg::IP_STEP);
		end else if (WORD_VALID) begin
			taken_reg <= take;
			if (take)
				instruction_pointer_reg <= PROGRAM_WORD[IP_W-1:0];
			else
				instruction_pointer_reg <= ip_advance(instruction_pointer_reg,
					bcu_pkg::IP_SKIP);
		end
	end

	// ==========================================================
	// Index register
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			index_counter_reg <= bcu_pkg::IDX_RESET;
		else if (state_reg == bcu_pkg::BCU_LOOP && WORD_VALID)
			index_counter_reg <= index_dec;
		else if (INDEX_LOAD)
			index_counter_reg <= INDEX_LOAD_VALUE;
	end

	assign INSTRUCTION_POINTER = instruction_pointer_reg;
	assign INDEX_COUNTER = index_counter_reg;
	assign BRANCH_BUSY = (state_reg != bcu_pkg::BCU_IDLE);
	assign BRANCH_TAKEN = taken_reg;

	// ==========================================================
	// Checks
	logic loop_exec;
	assign loop_exec = (state_reg == bcu_pkg::BCU_LOOP) && WORD_VALID;

	property p_jump_loads;
		@(posedge REF_CLK) disable iff (!RST_N)
		(state_reg == bcu_pkg::BCU_JUMP && WORD_VALID) |=>
			INSTRUCTION_POINTER == $past(PROGRAM_WORD[IP_W-1:0]);
	endproperty
	a_jump_loads: assert property (p_jump_loads)
		else $error("Jump target not loaded.");

	property p_loop_taken;
		@(posedge REF_CLK) disable iff (!RST_N)
		(loop_exec && index_counter_reg[8:0] != 9'h000) |=>
			INSTRUCTION_POINTER == $past(PROGRAM_WORD[IP_W-1:0]) && BRANCH_TAKEN;
	endproperty
	a_loop_taken: assert property (p_loop_taken)
		else $error("Loop jump not taken.");

	property p_loop_skip;
		@(posedge REF_CLK) disable iff (!RST_N)
		(loop_exec && index_counter_reg[8:0] == 9'h000) |=>
			INSTRUCTION_POINTER == $past(INSTRUCTION_POINTER) + 12'h002 &&
			!BRANCH_TAKEN;
	endproperty
	a_loop_skip: assert property (p_loop_skip)
		else $error("Loop skip wrong.");

	property p_loop_dec;
		@(posedge REF_CLK) disable iff (!RST_N)
		loop_exec |=> INDEX_COUNTER[8:0] == $past(INDEX_COUNTER[8:0]) - 9'h001;
	endproperty
	a_loop_dec: assert property (p_loop_dec)
		else $error("Index not decremented.");

	property p_one_taken;
		@(posedge REF_CLK) disable iff (!RST_N)
		(loop_exec && index_counter_reg[8:0] == 9'h001) |=>
			BRANCH_TAKEN && INDEX_COUNTER[8:0] == 9'h000;
	endproperty
	a_one_taken: assert property (p_one_taken)
		else $error("One must still jump.");

	property p_wrap;
		@(posedge REF_CLK) disable iff (!RST_N)
		(loop_exec && index_counter_reg[8:0] == 9'h000) |=>
			INDEX_COUNTER[8:0] == 9'h1FF;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("Index did not wrap.");

	property p_nonneg;
		@(posedge REF_CLK) disable iff (!RST_N)
		(state_reg == bcu_pkg::BCU_NONNEG && WORD_VALID) |=>
			BRANCH_TAKEN == !$past(ACCUMULATOR[ACC_W-1]);
	endproperty
	a_nonneg: assert property (p_nonneg)
		else $error("Sign test wrong.");

	property p_two_cycles;
		@(posedge REF_CLK) disable iff (!RST_N)
		(state_reg == bcu_pkg::BCU_IDLE && WORD_VALID &&
			PROGRAM_WORD == bcu_pkg::OP_JUMP) ##1 WORD_VALID |=> !BRANCH_BUSY;
	endproperty
	a_two_cycles: assert property (p_two_cycles)
		else $error("Branch not two words.");

	property p_plain_step;
		@(posedge REF_CLK) disable iff (!RST_N)
		(state_reg == bcu_pkg::BCU_IDLE && WORD_VALID &&
			PROGRAM_WORD != bcu_pkg::OP_JUMP &&
			PROGRAM_WORD != bcu_pkg::OP_LOOP_JUMP_NONZERO &&
			PROGRAM_WORD != bcu_pkg::OP_JUMP_IF_NONNEGATIVE) |=>
			INSTRUCTION_POINTER == $past(INSTRUCTION_POINTER) + 12'h001;
	endproperty
	a_plain_step: assert property (p_plain_step)
		else $error("Plain word did not step the pointer.");

	property p_opcode_waits;
		@(posedge REF_CLK) disable iff (!RST_N)
		(state_reg == bcu_pkg::BCU_IDLE && WORD_VALID &&
			(PROGRAM_WORD == bcu_pkg::OP_JUMP ||
			PROGRAM_WORD == bcu_pkg::OP_LOOP_JUMP_NONZERO ||
			PROGRAM_WORD == bcu_pkg::OP_JUMP_IF_NONNEGATIVE)) |=>
			BRANCH_BUSY && $stable(INSTRUCTION_POINTER);
	endproperty
	a_opcode_waits: assert property (p_opcode_waits)
		else $error("Opcode word moved the pointer.");

	property p_wait_holds;
		@(posedge REF_CLK) disable iff (!RST_N)
		(BRANCH_BUSY && !WORD_VALID) |=>
			BRANCH_BUSY && $stable(INSTRUCTION_POINTER);
	endproperty
	a_wait_holds: assert property (p_wait_holds)
		else $error("Branch did not wait for its target.");

	property p_nonneg_target;
		@(posedge REF_CLK) disable iff (!RST_N)
		(state_reg == bcu_pkg::BCU_NONNEG && WORD_VALID &&
			!ACCUMULATOR[ACC_W-1]) |=>
			INSTRUCTION_POINTER == $past(PROGRAM_WORD[IP_W-1:0]);
	endproperty
	a_nonneg_target: assert property (p_nonneg_target)
		else $error("Nonnegative target not loaded.");

	property p_nonneg_skip;
		@(posedge REF_CLK) disable iff (!RST_N)
		(state_reg == bcu_pkg::BCU_NONNEG && WORD_VALID &&
			ACCUMULATOR[ACC_W-1]) |=>
			INSTRUCTION_POINTER == $past(INSTRUCTION_POINTER) + 12'h002;
	endproperty
	a_nonneg_skip: assert property (p_nonneg_skip)
		else $error("Negative accumulator did not skip.");

	property p_loop_upper;
		@(posedge REF_CLK) disable iff (!RST_N)
		loop_exec |=> INDEX_COUNTER[15:9] == $past(INDEX_COUNTER[15:9]);
	endproperty
	a_loop_upper: assert property (p_loop_upper)
		else $error("Upper index bits changed.");

	property p_taken_pulse;
		@(posedge REF_CLK) disable iff (!RST_N)
		BRANCH_TAKEN |=> !BRANCH_TAKEN;
	endproperty
	a_taken_pulse: assert property (p_taken_pulse)
		else $error("Taken flag stood too long.");
endmodule : bcu_branch_unit
`default_nettype wire

// ### verilog/bcu_index_dec.sv
// Modulo-512 decrement of an index register and its nonzero test.
// Assumes the caller samples the test before applying the decrement.
`timescale 1ns/1ns
`default_nettype none
module bcu_index_dec #(
	parameter int WIDTH = 16
) (
	input wire logic [WIDTH-1:0] VALUE_IN,
	output logic [WIDTH-1:0] VALUE_OUT,
	output logic NONZERO
);
	if (WIDTH < bcu_pkg::IDX_COUNT_BITS) begin : g_bad_width
		$error("Index width too small.");
	end
	// modulo 512 wrap
	// Only the low bits count; upper bits are kept so software sees them.
	always_comb begin
		VALUE_OUT = VALUE_IN;
		VALUE_OUT[bcu_pkg::IDX_COUNT_BITS-1:0] =
			VALUE_IN[bcu_pkg::IDX_COUNT_BITS-1:0] - 9'h001;
	end
	assign NONZERO = |VALUE_IN[bcu_pkg::IDX_COUNT_BITS-1:0];
endmodule : bcu_index_dec
`default_nettype wire

// ### verilog/bcu_pkg.sv
// Constants for the branch control unit: opcodes, widths and reset values.
// Assumes a 16-bit program word and a 12-bit instruction pointer.
`default_nettype none
package bcu_pkg;
	// ==========================================================
	// Opcodes of the first word
	localparam logic [15:0] OP_JUMP = 16'hF900;
	localparam logic [15:0] OP_LOOP_JUMP_NONZERO = 16'hF400;
	localparam logic [15:0] OP_JUMP_IF_NONNEGATIVE = 16'hFD00;
	// ==========================================================
	// Widths and reset values
	localparam int IP_WIDTH = 12;
	localparam int IDX_WIDTH = 16;
	localparam int IDX_COUNT_BITS = 9;
	localparam int ACC_WIDTH = 32;
	localparam logic [11:0] IP_RESET = 12'h000;
	localparam logic [15:0] IDX_RESET = 16'h0000;
	localparam logic [11:0] IP_SKIP = 12'h002;
	localparam logic [11:0] IP_STEP = 12'h001;
	typedef enum logic [1:0] {
		BCU_IDLE = 2'b00,
		BCU_JUMP = 2'b01,
		BCU_LOOP = 2'b10,
		BCU_NONNEG = 2'b11
	} bcu_state_e;
endpackage : bcu_pkg
`default_nettype wire
